/* rtl/vector_select_ext_irq_defines.vh */
`ifndef VECTOR_SELECT_EXT_IRQ_DEFINES_VH
`define VECTOR_SELECT_EXT_IRQ_DEFINES_VH
// register byte addresses on apb
`define ADDR_MCU_CONTROL 12'h000
`define ADDR_SENSE_CONTROL 12'h004
`define ADDR_EXT_MASK 12'h008
`define ADDR_EXT_FLAG 12'h00C
`define ADDR_PC_ENABLE 12'h010
`define ADDR_PC_FLAG 12'h014
`define ADDR_PC_MASK_LO 12'h018
`define ADDR_PC_MASK_MID 12'h01C
`define ADDR_PC_MASK_HI 12'h020
`define ADDR_CORE_STATUS 12'h024
// mcu_control fields
`define BIT_UNLOCK 0
`define BIT_VSEL 1
// unlock window length, cycles; the interrupt block after an unlock write also covers the write cycle, one more
`define UNLOCK_CYCLES 3'h4
// sense codes
`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3
// idle level of the external interrupt pins
`define EXT_PIN_IDLE 2'h3
// word offset of the vector table within a section
`define VECTOR_TABLE_OFFSET 15'h0002
// flash word size and boot section sizes
`define FLASH_WORDS 16'h4000
`define BOOT_WORDS_0 16'h0800
`define BOOT_WORDS_1 16'h0400
`define BOOT_WORDS_2 16'h0200
`define BOOT_WORDS_3 16'h0100
`endif

/* rtl/vector_select_ext_irq.v */
// Added by the designer: the APB interface to the registers and the register offsets.
`include "vector_select_ext_irq_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module vector_select_ext_irq (
	input wire core_clk, // system clock
	input wire reset, // synchronous, active high
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error on unmapped address
	input wire [1:0] ext_irq_pins, // ext_irq_pin_b, ext_irq_pin_a levels
	input wire [23:0] pin_change_inputs, // pin change pins
	input wire [1:0] boot_size_fuses, // boot section size
	input wire app_section_boot_lock, // programmed high
	input wire boot_section_self_lock, // programmed high
	input wire global_irq_enable, // core status register i flag
	input wire exec_in_boot, // core fetching from boot section
	input wire instr_boundary, // core finished an instruction
	input wire [4:0] irq_ack, // handler entered: pc hi,mid,lo, ext b,a
	input wire io_clk_running, // low in sleep deeper than idle
	output reg [4:0] irq_request, // pc hi,mid,lo, ext b,a to core
	output reg irq_accept_enable, // core may accept interrupts
	output reg [15:0] vector_base, // word address of vector table
	output reg wake_request // asynchronous-class wake source
);
	reg vsel;
	reg unlock;
	reg [2:0] unlock_cnt;
	reg post_write_block;
	reg [3:0] sense;
	reg [1:0] ext_mask;
	wire [1:0] ext_flag;
	reg [2:0] pc_enable;
	wire [2:0] pc_flag;
	reg [7:0] pc_mask_lo;
	reg [6:0] pc_mask_mid;
	reg [7:0] pc_mask_hi;
	reg [1:0] ext_s1, ext_s2, ext_prev;
	reg [23:0] pc_s1, pc_s2, pc_prev;
	wire wr_access = psel & penable & pwrite;
	wire mcu_wr = wr_access && paddr == `ADDR_MCU_CONTROL;
	// a select write counts only inside an open window
	wire vsel_write = mcu_wr & unlock & ~pwdata[`BIT_UNLOCK];
	wire [23:0] pc_mask = {pc_mask_hi, 1'b0, pc_mask_mid, pc_mask_lo};
	wire [23:0] pc_toggle = (pc_s2 ^ pc_prev) & pc_mask;
	wire [2:0] pc_event;
	wire [1:0] ext_event;
	wire [1:0] ext_level;
	reg [15:0] boot_words;
	reg mapped;
	// vector change sequence and boot lock muting, combined into one gate
	wire unlock_write = mcu_wr & pwdata[`BIT_UNLOCK];
	wire change_block = unlock | unlock_write | post_write_block | vsel_write;
	wire app_mute = vsel & app_section_boot_lock & ~exec_in_boot;
	wire boot_mute = ~vsel & boot_section_self_lock & exec_in_boot;
	wire [15:0] boot_start = `FLASH_WORDS - boot_words;
	wire [15:0] next_vector_base = vsel ? boot_start + {1'b0, `VECTOR_TABLE_OFFSET} : {1'b0, `VECTOR_TABLE_OFFSET};
	genvar g;

	// sense decode and flag per external pin
	generate
		for (g = 0; g < 2; g = g + 1) begin : ext_pin
			wire [1:0] mode = sense[2*g+1:2*g];
			wire write_clear = wr_access && paddr == `ADDR_EXT_FLAG && pwdata[g];
			reg level_now;
			reg event_now;
			reg flag;
			assign ext_level[g] = level_now;
			assign ext_event[g] = event_now;
			assign ext_flag[g] = flag;
			always @* begin
				level_now = 1'b0;
				event_now = 1'b0;
				case (mode)
					`SENSE_LOW: begin
						level_now = ~ext_s2[g];
					end
					`SENSE_ANY: begin
						event_now = ext_s2[g] ^ ext_prev[g];
					end
					`SENSE_FALL: begin
						event_now = ext_prev[g] & ~ext_s2[g];
					end
					default: begin
						event_now = ~ext_prev[g] & ext_s2[g];
					end
				endcase
			end
			// level mode holds the flag at zero; an edge beats a clear in the same cycle
			always @(posedge core_clk) begin
				if (reset) begin
					flag <= 1'b0;
				end else if (mode == `SENSE_LOW) begin
					flag <= 1'b0;
				end else if (event_now) begin
					flag <= 1'b1;
				end else if (irq_ack[g] || write_clear) begin
					flag <= 1'b0;
				end
			end
		end
	endgenerate

	// per group toggle detection and flag, groups lo/mid/hi
	generate
		for (g = 0; g < 3; g = g + 1) begin : pc_group
			wire write_clear = wr_access && paddr == `ADDR_PC_FLAG && pwdata[g];
			reg flag;
			assign pc_event[g] = |pc_toggle[8*g+7:8*g];
			assign pc_flag[g] = flag;
			always @(posedge core_clk) begin
				if (reset) begin
					flag <= 1'b0;
				end else if (pc_event[g]) begin
					flag <= 1'b1;
				end else if (irq_ack[g+2] || write_clear) begin
					flag <= 1'b0;
				end
			end
		end
	endgenerate

	always @* begin
		case (boot_size_fuses)
			2'h0: begin
				boot_words = `BOOT_WORDS_0;
			end
			2'h1: begin
				boot_words = `BOOT_WORDS_1;
			end
			2'h2: begin
				boot_words = `BOOT_WORDS_2;
			end
			default: begin
				boot_words = `BOOT_WORDS_3;
			end
		endcase
	end

	always @* begin
		if (paddr == `ADDR_MCU_CONTROL) mapped = 1'b1;
		else if (paddr == `ADDR_SENSE_CONTROL) mapped = 1'b1;
		else if (paddr == `ADDR_EXT_MASK) mapped = 1'b1;
		else if (paddr == `ADDR_EXT_FLAG) mapped = 1'b1;
		else if (paddr == `ADDR_PC_ENABLE) mapped = 1'b1;
		else if (paddr == `ADDR_PC_FLAG) mapped = 1'b1;
		else if (paddr == `ADDR_PC_MASK_LO) mapped = 1'b1;
		else if (paddr == `ADDR_PC_MASK_MID) mapped = 1'b1;
		else if (paddr == `ADDR_PC_MASK_HI) mapped = 1'b1;
		else if (paddr == `ADDR_CORE_STATUS) mapped = 1'b1;
		else mapped = 1'b0;
	end

	// pins pass two flops; reset loads the idle level so no false edge follows
	// limitation: detection runs on core_clk, which stays up in deep sleep;
	// the io clock may stop, so nothing here depends on it
	always @(posedge core_clk) begin
		if (reset) begin
			ext_s1 <= `EXT_PIN_IDLE;
			ext_s2 <= `EXT_PIN_IDLE;
			ext_prev <= `EXT_PIN_IDLE;
		end else begin
			ext_s1 <= ext_irq_pins;
			ext_s2 <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	always @(posedge core_clk) begin
		if (reset) begin
			pc_s1 <= 24'h00_0000;
			pc_s2 <= 24'h00_0000;
			pc_prev <= 24'h00_0000;
		end else begin
			pc_s1 <= pin_change_inputs;
			pc_s2 <= pc_s1;
			pc_prev <= pc_s2;
		end
	end

	// vector select with unlock window
	always @(posedge core_clk) begin
		if (reset) begin
			vsel <= 1'b0;
			unlock <= 1'b0;
			unlock_cnt <= 3'h0;
			post_write_block <= 1'b0;
		end else begin
			if (vsel_write) begin
				vsel <= pwdata[`BIT_VSEL];
				unlock <= 1'b0;
				unlock_cnt <= 3'h0;
				post_write_block <= 1'b1;
			end else if (mcu_wr && pwdata[`BIT_UNLOCK]) begin
				unlock <= 1'b1;
				unlock_cnt <= `UNLOCK_CYCLES;
			end else if (unlock) begin
				unlock_cnt <= unlock_cnt - 3'h1;
				if (unlock_cnt == 3'h1)
					unlock <= 1'b0;
			end
			// held until the instruction after the select write completes
			if (!vsel_write && post_write_block && instr_boundary)
				post_write_block <= 1'b0;
		end
	end

	// configuration registers; flags live in the per-pin and per-group blocks
	always @(posedge core_clk) begin
		if (reset) begin
			sense <= 4'h0;
			ext_mask <= 2'h0;
			pc_enable <= 3'h0;
			pc_mask_lo <= 8'h00;
			pc_mask_mid <= 7'h00;
			pc_mask_hi <= 8'h00;
		end else if (wr_access) begin
			if (paddr == `ADDR_SENSE_CONTROL) begin
				sense <= pwdata[3:0];
			end else if (paddr == `ADDR_EXT_MASK) begin
				ext_mask <= pwdata[1:0];
			end else if (paddr == `ADDR_PC_ENABLE) begin
				pc_enable <= pwdata[2:0];
			end else if (paddr == `ADDR_PC_MASK_LO) begin
				pc_mask_lo <= pwdata[7:0];
			end else if (paddr == `ADDR_PC_MASK_MID) begin
				pc_mask_mid <= pwdata[6:0];
			end else if (paddr == `ADDR_PC_MASK_HI) begin
				pc_mask_hi <= pwdata[7:0];
			end
		end
	end

	// requests and core-facing outputs
	always @(posedge core_clk) begin
		if (reset) begin
			irq_request <= 5'h00;
			irq_accept_enable <= 1'b1;
			vector_base <= {1'b0, `VECTOR_TABLE_OFFSET};
			wake_request <= 1'b0;
		end else begin
			// a level dropped before wake-up finishes simply stops requesting
			irq_request[0] <= ext_mask[0] & (ext_flag[0] | ext_level[0]);
			irq_request[1] <= ext_mask[1] & (ext_flag[1] | ext_level[1]);
			irq_request[4:2] <= pc_enable & pc_flag;
			wake_request <= |(ext_mask & (ext_flag | ext_level)) | |(pc_enable & pc_flag);
			// global enable is only read, never written here
			irq_accept_enable <= ~change_block & ~app_mute & ~boot_mute;
			vector_base <= next_vector_base;
		end
	end

	// apb slave: zero wait states, error on unmapped address
	always @(posedge core_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (paddr == `ADDR_MCU_CONTROL) prdata <= {30'h0, vsel, unlock};
				else if (paddr == `ADDR_SENSE_CONTROL) prdata <= {28'h0, sense};
				else if (paddr == `ADDR_EXT_MASK) prdata <= {30'h0, ext_mask};
				else if (paddr == `ADDR_EXT_FLAG) prdata <= {30'h0, ext_flag};
				else if (paddr == `ADDR_PC_ENABLE) prdata <= {29'h0, pc_enable};
				else if (paddr == `ADDR_PC_FLAG) prdata <= {29'h0, pc_flag};
				else if (paddr == `ADDR_PC_MASK_LO) prdata <= {24'h0, pc_mask_lo};
				else if (paddr == `ADDR_PC_MASK_MID) prdata <= {25'h0, pc_mask_mid};
				else if (paddr == `ADDR_PC_MASK_HI) prdata <= {24'h0, pc_mask_hi};
				else if (paddr == `ADDR_CORE_STATUS) prdata <= {29'h0, io_clk_running, global_irq_enable, irq_accept_enable};
			end
		end
	end
endmodule // vector_select_ext_irq
`default_nettype wire

/* testbench/vector_select_ext_irq_props.sv */
`timescale 1ns/10ps
`default_nettype none
module vsei_props (
	input wire logic core_clk, // clock
	input wire logic reset, // sync reset
	input wire logic psel, // apb select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [1:0] boot_size_fuses, // boot size
	input wire logic app_section_boot_lock, // app lock
	input wire logic boot_section_self_lock, // boot lock
	input wire logic exec_in_boot, // fetch region
	input wire logic irq_accept_enable, // accept gate
	input wire logic [15:0] vector_base // table base
);
	wire unl = psel && penable && pwrite && paddr == 12'h000 && pwdata[0];
	wire nolock = !app_section_boot_lock && !boot_section_self_lock;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_RESET_STATE: assert property ($fell(reset) |-> vector_base == 16'h0002 && irq_accept_enable && !pready)
		else $error("bad state after reset");
	AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("pslverr without pready or with data");
	AST_BASE:
		assert property ($changed(vector_base) |-> vector_base == 16'h0002
			|| vector_base == 16'h4002 - (16'h0800 >> boot_size_fuses))
		else $error("vector base not from fuses");
	AST_BLOCK: assert property (unl |=> !irq_accept_enable [*3])
		else $error("interrupts not blocked after unlock");
	AST_RESUME: assert property (unl && nolock |-> ##[2:12] irq_accept_enable)
		else $error("interrupts stay blocked");
	AST_APP_LOCK:
		assert property (app_section_boot_lock && $past(app_section_boot_lock) && vector_base != 16'h0002
			&& $stable(vector_base) && !exec_in_boot && !$past(exec_in_boot) |-> !irq_accept_enable)
		else $error("interrupt open in application");
	AST_BOOT_LOCK:
		assert property (boot_section_self_lock && $past(boot_section_self_lock) && vector_base == 16'h0002
			&& exec_in_boot && $past(exec_in_boot) |-> !irq_accept_enable)
		else $error("interrupt open in boot section");
	cover property (unl);
	cover property (pslverr);
	cover property (app_section_boot_lock && !irq_accept_enable);
endmodule // vsei_props
`default_nettype wire

/* testbench/core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic core_clk, // clock
	input wire logic reset, // sync reset
	input wire logic take_en, // allow handler entry
	input wire logic [4:0] irq_request, // pending requests
	input wire logic irq_accept_enable, // accept gate
	output logic instr_boundary, // instruction done
	output logic [4:0] irq_ack // handler entered
);
	logic ph;
	// two-cycle instructions, so the post-select block ends on a boundary
	always @(posedge core_clk) begin
		ph <= reset ? 1'b0 : !ph;
		instr_boundary <= !reset && ph;
		irq_ack <= 5'h00;
		if (!reset && take_en && irq_accept_enable && irq_request != 5'h00 && irq_ack == 5'h00) begin
			irq_ack <= irq_request & -irq_request;
		end
	end
endmodule // core_model
`default_nettype wire

/* testbench/vector_select_ext_irq_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("unexpected at %0t: value mismatch", $time); end end
module vector_select_ext_irq_tb;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err, take_en, wake_request;
	logic app_section_boot_lock, boot_section_self_lock, exec_in_boot, instr_boundary, irq_accept_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] ext_irq_pins, boot_size_fuses;
	logic [23:0] pin_change_inputs;
	logic [4:0] irq_ack, irq_request;
	logic [15:0] vector_base;
	int fail_count = 0;
	int n_compared = 0;
	vector_select_ext_irq i_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ext_irq_pins, .pin_change_inputs, .boot_size_fuses, .app_section_boot_lock,
		.boot_section_self_lock, .global_irq_enable(1'b1), .exec_in_boot, .instr_boundary, .irq_ack,
		.io_clk_running(1'b1), .irq_request, .irq_accept_enable, .vector_base, .wake_request);
	core_model i_core (.core_clk, .reset, .take_en, .irq_request, .irq_accept_enable, .instr_boundary, .irq_ack);
	task automatic give_verdict();
		$display("compared %0d, failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 8);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (k >= 8) begin fail_count++; give_verdict(); end
	endtask
	task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask
	task automatic regs_reset();
		bus(0, 12'h000, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
		`CHK(vector_base, 16'h0002)
		bus(0, 12'h024, 32'h0000_0000); `CHK(rd[2:0], 3'h7)
		bus(1, 12'h03C, 32'h0000_0001); `CHK(err, 1'b1)
	endtask
	task automatic lapse();
		bus(1, 12'h000, 32'h0000_0001); tick(1); `CHK(irq_accept_enable, 1'b0)
		tick(8); `CHK(irq_accept_enable, 1'b1)
		bus(0, 12'h000, 32'h0000_0000); `CHK(rd[0], 1'b0)
		bus(1, 12'h000, 32'h0000_0002); tick(2); `CHK(vector_base, 16'h0002)
	endtask
	task automatic home();
		bus(1, 12'h000, 32'h0000_0001); bus(1, 12'h000, 32'h0000_0000); tick(2);
		`CHK(vector_base, 16'h0002)
	endtask
	task automatic move(input logic [1:0] f);
		boot_size_fuses <= f;
		bus(1, 12'h000, 32'h0000_0001); bus(1, 12'h000, 32'h0000_0002); tick(2);
		`CHK(vector_base, 16'h4002 - (16'h0800 >> f))
		bus(0, 12'h000, 32'h0000_0000); `CHK(rd[1:0], 2'h2)
	endtask
	task automatic locks();
		app_section_boot_lock <= 1'b1; tick(3); `CHK(irq_accept_enable, 1'b0)
		exec_in_boot <= 1'b1; tick(3); `CHK(irq_accept_enable, 1'b1)
		app_section_boot_lock <= 1'b0; home();
		boot_section_self_lock <= 1'b1; tick(3); `CHK(irq_accept_enable, 1'b0)
		boot_section_self_lock <= 1'b0; exec_in_boot <= 1'b0; tick(3);
	endtask
	task automatic ext_pins();
		bus(1, 12'h004, 32'h0000_0000); bus(1, 12'h008, 32'h0000_0001);
		ext_irq_pins <= 2'b10; tick(6); `CHK(irq_request[0], 1'b1)
		`CHK(wake_request, 1'b1)
		bus(0, 12'h00C, 32'h0000_0000); `CHK(rd[0], 1'b0)
		ext_irq_pins <= 2'b11; tick(6); `CHK(irq_request[0], 1'b0)
		for (int c = 1; c < 4; c++) begin
			bus(1, 12'h004, c); tick(2);
			ext_irq_pins <= 2'b10; tick(6); `CHK(irq_request[0], c != 3)
			bus(1, 12'h00C, 32'h0000_0001); tick(2);
			ext_irq_pins <= 2'b11; tick(6); `CHK(irq_request[0], c != 2)
			bus(1, 12'h00C, 32'h0000_0001); tick(2); `CHK(irq_request[0], 1'b0)
		end
	endtask
	task automatic pin_change();
		bus(1, 12'h010, 32'h0000_0001); bus(1, 12'h018, 32'h0000_0008);
		pin_change_inputs <= 24'h00_0010; tick(6); `CHK(irq_request[2], 1'b0)
		pin_change_inputs <= 24'h00_0018; tick(6); `CHK(irq_request[2], 1'b1)
		take_en <= 1'b1; tick(4); take_en <= 1'b0; tick(2); `CHK(irq_request, 5'h00)
	endtask
	initial begin core_clk = 1'b0; forever #5 core_clk = ~core_clk; end
	initial begin
		reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
		ext_irq_pins = 2'b11; pin_change_inputs = 24'h00_0000; boot_size_fuses = 2'h0; take_en = 1'b0;
		app_section_boot_lock = 1'b0; boot_section_self_lock = 1'b0; exec_in_boot = 1'b0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		regs_reset();
		lapse();
		for (int f = 0; f < 4; f++) begin home(); move(f[1:0]); end
		locks();
		ext_pins();
		pin_change();
		give_verdict();
	end
	// a hung handshake must still end the run
	initial begin repeat (20000) @(posedge core_clk); fail_count++; give_verdict(); end
endmodule // vector_select_ext_irq_tb
bind vector_select_ext_irq vsei_props i_props (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .boot_size_fuses, .app_section_boot_lock, .boot_section_self_lock, .exec_in_boot,
	.irq_accept_enable, .vector_base);
`default_nettype wire
